// ===== bench/cfa_store_model.sv
// byte-wide data store model answering reads combinationally in the cycle its read strobe is high
`timescale 1ns/100ps
`default_nettype none
module cfa_store_model (
  input  wire logic        clock,
  input  wire logic        rd,
  input  wire logic [15:0] addr,
  output logic [7:0]       rdata
);
  logic [7:0] last_q = 8'hA5;

  // contents follow the address; off-cycle shows the inverted last byte so
  // a design that samples late never sees a stale match
  assign rdata = rd ? (addr[7:0] ^ addr[15:8] ^ 8'h5A) : ~last_q;

  // remember the byte handed out
  always_ff @(posedge clock) begin
    if (rd) begin
      last_q <= rdata;
    end
  end
endmodule : cfa_store_model
`default_nettype wire

// ===== bench/tb_cpu_execute_flags_addressing.sv
// self-checking bench for the execute stage
`timescale 1ns/100ps
`default_nettype none
module tb_cpu_execute_flags_addressing;
  import cfa_pkg::*;
  logic        clock, reset, instr_valid, stk_full, stk_empty, ev0, ev1, wake_up;
  logic        rd_q, busy_q, rv_q, jt_q, halted_q, clk_en_q, bus_write, bus_read;
  logic        jt, rd_seen, bsy, c, v, z, hlt;
  logic [1:0]  bus_addr;
  logic [2:0]  div;
  logic [7:0]  r3, rdata, bus_wdata, bus_rdata_q, d;
  logic [15:0] addr_q, rd_addr, p, ea;
  logic [63:0] ptr_q;
  cfa_instr_s  instr, ins;
  cfa_result_s res_q, res;
  int          failures, cmp_count, i, k, n;
  // compare pairs and the expected jump outcome per condition code
  logic [7:0]  cx[3] = '{8'h05, 8'h09, 8'h05};
  logic [7:0]  cy[3] = '{8'h05, 8'h05, 8'h07};
  logic [12:0] cj[3] = '{13'b1010010100101, 13'b0011100011001, 13'b1100100101010};
  // single-operand table: op, x, y, bit or shift, accumulator, register
  cfa_op_e     top[9] = '{OP_MUL, OP_MSHL, OP_MSHR, OP_MSHRA, OP_TSTB, OP_TSTB,
                          OP_SETB, OP_CLRB, OP_INVB};
  logic [7:0]  tx[9] = '{8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0]  ty[9] = '{8'hFF, 8'h81, 8'h80, 8'h80, 8'hA5, 8'hA5, 8'h00, 8'hFF, 8'h0F};
  logic [2:0]  ts[9] = '{3'h0, 3'h3, 3'h1, 3'h1, 3'h2, 3'h1, 3'h7, 3'h0, 3'h3};
  logic [7:0]  ta[9] = '{8'h01, 8'h08, 8'h00, 8'h00, 8'h04, 8'h00, 8'h80, 8'hFE, 8'h07};
  logic [7:0]  tr[9] = '{8'hFE, 8'h04, 8'h40, 8'hC0, 8'h00, 8'h00, 8'h80, 8'hFE, 8'h07};

  cfa_execute #(.PTR_W(16)) i_dut (
    .clock(clock), .reset(reset), .instr_valid(instr_valid), .instr(instr),
    .offset_register_three(r3), .call_stack_full(stk_full),
    .call_stack_empty(stk_empty), .event_line_zero(ev0), .event_line_one(ev1),
    .wake_up(wake_up), .data_store_rdata(rdata), .data_store_addr_q(addr_q),
    .data_store_rd_q(rd_q), .busy_q(busy_q), .result_q(res_q),
    .result_valid_q(rv_q), .jump_taken_q(jt_q), .halted_q(halted_q),
    .cpu_clk_en_q(clk_en_q), .pointer_register_q(ptr_q), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_write(bus_write), .bus_read(bus_read),
    .bus_rdata_q(bus_rdata_q)
  );

  cfa_store_model i_store (
    .clock(clock), .rd(rd_q), .addr(addr_q), .rdata(rdata)
  );

  task automatic chk(string name, logic [15:0] seen, logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic print_verdict();
    if (failures == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict

  // offer one instruction for exactly one cycle
  task automatic issue();
    @(posedge clock);
    instr_valid <= 1'b1;
    instr <= ins;
    @(posedge clock);
    instr_valid <= 1'b0;
  endtask : issue

  // issue and wait a bounded time for the result pulse
  task automatic exec();
    issue();
    rd_seen = 1'b0;
    bsy = 1'b0;
    for (n = 0; n < 4; n++) begin
      #1;
      if (rd_q === 1'b1) begin
        rd_seen = 1'b1;
        rd_addr = addr_q;
        bsy = busy_q;
      end
      if (rv_q === 1'b1) begin
        res = res_q;
        jt = jt_q;
        return;
      end
      @(posedge clock);
    end
    failures++;
    print_verdict();
  endtask : exec

  task automatic run_op(cfa_op_e op, logic [7:0] x, logic [7:0] y, logic [2:0] sel);
    ins = '0;
    ins.op = op;
    ins.x = x;
    ins.y = y;
    ins.sel = sel;
    exec();
  endtask : run_op

  task automatic bus_rd(logic [1:0] a, output logic [7:0] q);
    @(posedge clock);
    bus_read <= 1'b1;
    bus_addr <= a;
    @(posedge clock);
    bus_read <= 1'b0;
    #1;
    q = bus_rdata_q;
  endtask : bus_rd

  task automatic bus_wr(logic [1:0] a, logic [7:0] w);
    @(posedge clock);
    bus_write <= 1'b1;
    bus_addr <= a;
    bus_wdata <= w;
    @(posedge clock);
    bus_write <= 1'b0;
  endtask : bus_wr

  // status byte against the flags tracked here
  task automatic st_chk();
    bus_rd(2'h0, d);
    chk("status", {8'h00, d}, {8'h00, 1'b0, div, hlt, z, v, c});
  endtask : st_chk

  // a wake pin release is synchronised, so allow a few cycles
  task automatic wait_wake();
    for (k = 0; k < 10; k++) begin
      @(posedge clock);
      #1;
      if (halted_q === 1'b0) begin
        hlt = 1'b0;
        return;
      end
    end
    failures++;
    print_verdict();
  endtask : wait_wake

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  initial begin
    {reset, c, v, z, hlt} = 5'h10;
    {instr_valid, ev0, ev1, wake_up, bus_write, bus_read, stk_empty} = '0;
    stk_full = 1'b1;
    ins = '0;
    instr = '0;
    r3 = 8'h33;
    {bus_addr, bus_wdata, div} = '0;
    failures = 0;
    cmp_count = 0;
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    st_chk();
    bus_rd(2'h3, d);
    chk("unmapped", {8'h00, d}, 16'h0000);
    bus_wr(2'h2, 8'hFF);
    bus_rd(2'h1, d);
    chk("ctrl read", {8'h00, d}, 16'h0000);
    // borrow chain: carry starts clear, so the first subtract borrows one more
    for (i = 0; i < 3; i++) begin
      run_op(OP_SUBC, cx[i] + 8'h03, cy[i], 3'h0);
      {c, ea[7:0]} = {1'b1, cx[i] + 8'h03} - {1'b0, cy[i]} - {8'h00, ~c};
      chk("subc acc", {8'h00, res.acc}, {8'h00, ea[7:0]});
      bus_rd(2'h0, d);
      chk("subc carry", {15'h0, d[0]}, {15'h0, c});
    end
    // zero minus one with carry set must borrow and clear carry
    run_op(OP_SUBC, 8'h00, 8'h01, 3'h0);
    chk("subc under", {8'h00, res.acc}, 16'h00FF);
    c = 1'b0;
    st_chk();
    for (i = 0; i < 3; i++) begin
      run_op(OP_CMP, cx[i], cy[i], 3'h0);
      chk("cmp acc", {8'h00, res.acc}, {8'h00, 8'(cx[i] - cy[i])});
      chk("cmp reg_we", {15'h0, res.reg_we}, 16'h0000);
      c = cx[i] >= cy[i];
      z = cx[i] == cy[i];
      v = c & ~z;
      st_chk();
      for (k = 0; k < 13; k++) begin
        ins = '0;
        ins.op = OP_JUMP;
        ins.cc = cfa_cc_e'(k);
        exec();
        chk("jump", {15'h0, jt}, {15'h0, cj[i][k]});
      end
      // walk the stack status pins so both bits are seen in both states
      @(posedge clock);
      {stk_full, stk_empty} <= 2'(i + 1);
      run_op(OP_SFLAG, 8'h00, 8'h00, 3'h0);
      chk("sflag", {8'h00, res.acc}, {8'h00, c, c ^ v, stk_full, stk_empty, 4'h0});
      st_chk();
    end
    @(posedge clock);
    ev1 <= 1'b1;
    repeat (4) @(posedge clock);
    ins = '0;
    ins.op = OP_JUMP;
    ins.cc = CC_EV;
    exec();
    chk("jump ev", {15'h0, jt}, 16'h0001);
    @(posedge clock);
    ev1 <= 1'b0;
    run_op(OP_RFLAG, 8'h00, 8'h81, 3'h0);
    chk("rflag acc", {8'h00, res.acc}, 16'h0002);
    c = 1'b1;
    st_chk();
    // no-operation must write nothing and leave every flag alone
    run_op(OP_NOP, 8'hFF, 8'hFF, 3'h7);
    chk("nop we", {14'h0, res.acc_we, res.reg_we}, 16'h0000);
    st_chk();
    for (i = 0; i < 9; i++) begin
      run_op(top[i], tx[i], ty[i], ts[i]);
      chk("acc", {8'h00, res.acc}, {8'h00, ta[i]});
      chk("acc_we", {15'h0, res.acc_we}, 16'h0001);
      chk("reg_we", {15'h0, res.reg_we}, {15'h0, top[i] != OP_TSTB});
      if (top[i] != OP_TSTB) begin
        chk("reg", {8'h00, res.reg_v}, {8'h00, tr[i]});
      end
      if (top[i] >= OP_TSTB) begin
        z = ta[i] == 8'h00;
      end
      st_chk();
    end
    // two laps through the modes so pointer side effects compound
    p = 16'h0000;
    for (i = 0; i < 16; i++) begin
      ins = '0;
      ins.op = OP_MUL;
      ins.y = 8'h01;
      ins.mem_slot = 2'h1;
      ins.ptr_sel = 2'h2;
      ins.imm = 8'h10;
      ins.mode = cfa_mode_e'(i % 8);
      case (i % 8)
        0: ea = 16'h0010;
        1: ea = p;
        2: ea = p + 16'h0010;
        3: ea = p + 16'h0033;
        4: begin
          ea = p;
          p = p + 16'h0001;
        end
        5: begin
          ea = p + 16'h0010;
          p = ea;
        end
        6: begin
          p = p - 16'h0001;
          ea = p;
        end
        default: begin
          p = p - 16'h0010;
          ea = p;
        end
      endcase
      exec();
      chk("rd", {15'h0, rd_seen}, 16'h0001);
      chk("busy", {15'h0, bsy}, 16'h0001);
      chk("addr", rd_addr, ea);
      chk("mem acc", {8'h00, res.acc}, {8'h00, ea[7:0] ^ ea[15:8] ^ 8'h5A});
      chk("ptr", ptr_q[47:32], p);
    end
    chk("ptr0", ptr_q[15:0], 16'h0000);
    for (i = 0; i < 2; i++) begin
      ins = '0;
      ins.op = OP_HALT;
      issue();
      repeat (2) @(posedge clock);
      #1;
      chk("halted", {15'h0, halted_q}, 16'h0001);
      if (i == 0) begin
        hlt = 1'b1;
        st_chk();
        ins.op = OP_SETB;
        issue();
        n = 0;
        repeat (4) begin
          @(posedge clock);
          #1;
          n += rv_q;
        end
        chk("refused", 16'(n), 16'h0000);
        bus_wr(2'h1, 8'h01);
      end else begin
        @(posedge clock);
        wake_up <= 1'b1;
      end
      wait_wake();
      @(posedge clock);
      wake_up <= 1'b0;
    end
    st_chk();
    for (i = 0; i < 6; i++) begin
      ins = '0;
      ins.op = OP_FREQ;
      ins.divn = 3'(i);
      exec();
      div = (i > 4) ? 3'h4 : 3'(i);
      st_chk();
      repeat (16) @(posedge clock);
      n = 0;
      repeat (32) begin
        @(posedge clock);
        #1;
        n += clk_en_q;
      end
      chk("clk_en", 16'(n), 16'(32 >> div));
    end
    print_verdict();
  end
endmodule : tb_cpu_execute_flags_addressing
`default_nettype wire

// ===== hdl/cfa_execute.sv
// execute stage: arithmetic, bit, flag, jump, halt and data-store addressing logic
//
// Summary of operation
// - subtract with borrow: x minus y minus inverted carry; carry clear on underflow
// - multiply forms 16-bit product; low byte to accumulator, high byte to register
// - shift left multiplies register by two to the 3-bit immediate power
// - shift right multiplies by two to eight minus shift; one is not one-bit shift
// - compare writes difference to accumulator only; overflow is carry and not zero
// - bit test copies selected bit into accumulator, other bits zero, updates zero
// - bit set forces selected bit to one, result also to accumulator
// - bit clear forces selected bit to zero, result also to accumulator
// - bit invert complements selected bit, result also to accumulator
// - flag save packs carry, carry xor overflow, stack full and empty into accumulator
// - flag restore shifts operand left into accumulator, carry from operand bit seven
// - frequency sets cpu clock divider to none, two, four, eight or sixteen
// - eight addressing modes; direct mode uses a zero upper byte and 8-bit field
// - indexed modes pick one of four pointers; plain indexed uses it unchanged
// - offset modes add immediate or register three to pointer, pointer unchanged
// - post-increment accesses pointer or pointer plus offset, then adds one or offset
// - pre-decrement accesses pointer minus one or offset and stores it back
// - memory access and pointer update belong to the same instruction
// - jumps test carry, zero, overflow, event lines and six compare relations
`timescale 1ns/100ps
`default_nettype none
`include "cfa_defines.svh"
module cfa_execute #(
  parameter int PTR_W = 16
) (
  input  wire logic                 clock,
  input  wire logic                 reset,
  input  wire logic                 instr_valid,
  input  wire cfa_pkg::cfa_instr_s  instr,
  input  wire logic [7:0]           offset_register_three,
  input  wire logic                 call_stack_full,
  input  wire logic                 call_stack_empty,
  input  wire logic                 event_line_zero,
  input  wire logic                 event_line_one,
  input  wire logic                 wake_up,
  input  wire logic [7:0]           data_store_rdata,
  output logic [PTR_W-1:0]          data_store_addr_q,
  output logic                      data_store_rd_q,
  output logic                      busy_q,
  output cfa_pkg::cfa_result_s      result_q,
  output logic                      result_valid_q,
  output logic                      jump_taken_q,
  output logic                      halted_q,
  output logic                      cpu_clk_en_q,
  output logic [4*PTR_W-1:0]        pointer_register_q,
  input  wire logic [1:0]           bus_addr,
  input  wire logic [7:0]           bus_wdata,
  input  wire logic                 bus_write,
  input  wire logic                 bus_read,
  output logic [7:0]                bus_rdata_q
);
  import cfa_pkg::*;

  typedef enum logic {ST_IDLE, ST_MEM} cfa_state_e;

  cfa_state_e  state_q;
  cfa_instr_s  held_q;
  cfa_instr_s  cur;
  logic        c_q, v_q, z_q;
  logic [2:0]  div_q;
  logic [4:0]  div_cnt_q;
  logic [1:0]  ev0_sync_q, ev1_sync_q, wake_sync_q;
  logic        issue, exec;
  logic [7:0]  ox, oy, ofs;
  logic [15:0] prod;
  logic [7:0]  acc_d, reg_d;
  logic        acc_we_d, reg_we_d, c_d, v_d, z_we;
  logic [8:0]  diff;
  logic [PTR_W-1:0] base, ea_d, ptr_d;
  logic        ptr_we, cond;
  logic [PTR_W-1:0] ptr_q [4];
  logic        wake_wr;

  // event and wake pins pass two flops; only the second stage is read
  always_ff @(posedge clock) begin
    if (reset) begin
      ev0_sync_q  <= 2'h0;
      ev1_sync_q  <= 2'h0;
      wake_sync_q <= 2'h0;
    end else begin
      ev0_sync_q  <= {ev0_sync_q[0], event_line_zero};
      ev1_sync_q  <= {ev1_sync_q[0], event_line_one};
      wake_sync_q <= {wake_sync_q[0], wake_up};
    end
  end

  // a memory instruction issues its access first, then executes with the fetched byte
  assign issue = (state_q == ST_IDLE) && instr_valid && !halted_q && (instr.mem_slot != 2'h0);
  assign exec  = (state_q == ST_MEM) ||
                 ((state_q == ST_IDLE) && instr_valid && !halted_q && (instr.mem_slot == 2'h0));
  assign cur   = (state_q == ST_MEM) ? held_q : instr;
  assign ox    = (state_q == ST_MEM && held_q.mem_slot == 2'h1) ? data_store_rdata : cur.x;
  assign oy    = (state_q == ST_MEM && held_q.mem_slot == 2'h2) ? data_store_rdata : cur.y;

  always_ff @(posedge clock) begin
    if (reset) begin
      state_q <= ST_IDLE;
      held_q  <= '0;
      busy_q  <= 1'b0;
    end else if (issue) begin
      state_q <= ST_MEM;
      held_q  <= instr;
      busy_q  <= 1'b1;
    end else begin
      state_q <= ST_IDLE;
      busy_q  <= 1'b0;
    end
  end

  // effective address and pointer side effect, both fixed at issue time
  always_comb begin
    base   = ptr_q[instr.ptr_sel];
    ofs    = (instr.mode == AM_IDX_R3) ? offset_register_three : instr.imm;
    ea_d   = base;
    ptr_d  = base;
    ptr_we = 1'b0;
    unique case (instr.mode)
      AM_DIRECT:   ea_d = PTR_W'({`CFA_DIRECT_PAGE, instr.imm});
      AM_IDX:      ea_d = base;
      AM_IDX_IMM,
      AM_IDX_R3:   ea_d = base + PTR_W'(ofs);
      AM_POST_INC: begin
        ptr_d  = base + PTR_W'(1);
        ptr_we = 1'b1;
      end
      AM_POST_OFS: begin
        ea_d   = base + PTR_W'(ofs);
        ptr_d  = base + PTR_W'(ofs);
        ptr_we = 1'b1;
      end
      AM_PRE_DEC: begin
        ea_d   = base - PTR_W'(1);
        ptr_d  = base - PTR_W'(1);
        ptr_we = 1'b1;
      end
      AM_PRE_OFS: begin
        ea_d   = base - PTR_W'(ofs);
        ptr_d  = base - PTR_W'(ofs);
        ptr_we = 1'b1;
      end
    endcase
  end

  // access and pointer update happen together for the issuing instruction
  always_ff @(posedge clock) begin
    if (reset) begin
      data_store_addr_q <= '0;
      data_store_rd_q   <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        ptr_q[i] <= PTR_W'(`CFA_RST_PTR);
      end
    end else begin
      data_store_rd_q <= issue;
      if (issue) begin
        data_store_addr_q <= ea_d;
      end
      if (issue && ptr_we) begin
        ptr_q[instr.ptr_sel] <= ptr_d;
      end
    end
  end

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pointer_register_q[i*PTR_W +: PTR_W] = ptr_q[i];
    end
  end

  // the datapath proper; flags that an op leaves alone keep their value
  always_comb begin
    prod     = 16'h0000;
    diff     = 9'h000;
    acc_d    = 8'h00;
    reg_d    = oy;
    acc_we_d = 1'b0;
    reg_we_d = 1'b0;
    c_d      = c_q;
    v_d      = v_q;
    z_we     = 1'b0;
    unique case (cur.op)
      OP_SUBC: begin
        diff     = {1'b0, ox} - {1'b0, oy} - {8'h00, ~c_q};
        acc_d    = diff[7:0];
        reg_d    = diff[7:0];
        c_d      = ~diff[8];
        acc_we_d = 1'b1;
        reg_we_d = 1'b1;
        z_we     = 1'b1;
      end
      OP_MUL: begin
        prod     = {8'h00, ox} * {8'h00, oy};
        acc_d    = prod[7:0];
        reg_d    = prod[15:8];
        acc_we_d = 1'b1;
        reg_we_d = 1'b1;
      end
      OP_MSHL: begin
        prod     = {8'h00, oy} << cur.sel;
        acc_d    = prod[7:0];
        reg_d    = prod[15:8];
        acc_we_d = 1'b1;
        reg_we_d = 1'b1;
      end
      OP_MSHR,
      OP_MSHRA: begin
        // shift of one lands seven places left, not one right: hardware multiplies
        prod     = (cur.op == OP_MSHRA) ? ({{8{oy[7]}}, oy} << (4'h8 - {1'b0, cur.sel}))
                                        : ({8'h00, oy} << (4'h8 - {1'b0, cur.sel}));
        acc_d    = prod[7:0];
        reg_d    = prod[15:8];
        acc_we_d = 1'b1;
        reg_we_d = 1'b1;
      end
      OP_CMP: begin
        diff     = {1'b0, ox} - {1'b0, oy};
        acc_d    = diff[7:0];
        c_d      = ~diff[8];
        v_d      = ~diff[8] && (diff[7:0] != 8'h00);
        acc_we_d = 1'b1;
        z_we     = 1'b1;
      end
      OP_TSTB: begin
        acc_d    = oy & (8'h01 << cur.sel);
        acc_we_d = 1'b1;
        z_we     = 1'b1;
      end
      OP_SETB,
      OP_CLRB,
      OP_INVB: begin
        reg_d = oy;
        if (cur.op == OP_SETB) begin
          reg_d[cur.sel] = 1'b1;
        end else if (cur.op == OP_CLRB) begin
          reg_d[cur.sel] = 1'b0;
        end else begin
          reg_d[cur.sel] = ~oy[cur.sel];
        end
        acc_d    = reg_d;
        acc_we_d = 1'b1;
        reg_we_d = 1'b1;
        z_we     = 1'b1;
      end
      OP_SFLAG: begin
        acc_d    = {c_q, c_q ^ v_q, call_stack_full, call_stack_empty, 4'h0};
        acc_we_d = 1'b1;
      end
      OP_RFLAG: begin
        acc_d    = {oy[6:0], 1'b0};
        c_d      = oy[7];
        acc_we_d = 1'b1;
        z_we     = 1'b1;
      end
      default: begin
        acc_d = 8'h00;
      end
    endcase
  end

  // jump condition; compare relations use the flags that compare left
  always_comb begin
    unique case (cur.cc)
      CC_CS:   cond = c_q;
      CC_CC:   cond = ~c_q;
      CC_ZS:   cond = z_q;
      CC_ZC:   cond = ~z_q;
      CC_VS:   cond = v_q;
      CC_VC:   cond = ~v_q;
      CC_EV:   cond = ev0_sync_q[1] | ev1_sync_q[1];
      CC_EQ:   cond = z_q;
      CC_NE:   cond = ~z_q;
      CC_GT:   cond = c_q & ~z_q;
      CC_GE:   cond = c_q;
      CC_LT:   cond = ~c_q;
      CC_LE:   cond = ~c_q | z_q;
      default: cond = 1'b0;
    endcase
  end

  // results and flags are registered so every output comes from a flop
  always_ff @(posedge clock) begin
    if (reset) begin
      result_q       <= '0;
      result_valid_q <= 1'b0;
      jump_taken_q   <= 1'b0;
      c_q            <= 1'b0;
      v_q            <= 1'b0;
      z_q            <= 1'b0;
    end else begin
      result_valid_q <= exec;
      jump_taken_q   <= exec && (cur.op == OP_JUMP) && cond;
      result_q       <= '{acc_we: exec & acc_we_d, acc: acc_d,
                          reg_we: exec & reg_we_d, reg_v: reg_d};
      if (exec) begin
        c_q <= c_d;
        v_q <= v_d;
        if (z_we) begin
          z_q <= (acc_d == 8'h00);
        end
      end
    end
  end

  // halt holds until the wake pin or a software wake; wake wins over a new halt
  assign wake_wr = bus_write && (bus_addr == `CFA_OFS_CTRL) && bus_wdata[`CFA_CTRL_WAKE];
  always_ff @(posedge clock) begin
    if (reset) begin
      halted_q <= 1'b0;
    end else if (wake_sync_q[1] || wake_wr) begin
      halted_q <= 1'b0;
    end else if (exec && cur.op == OP_HALT) begin
      halted_q <= 1'b1;
    end
  end

  // divider select; codes above the largest division are clamped
  always_ff @(posedge clock) begin
    if (reset) begin
      div_q <= `CFA_RST_DIV;
    end else if (exec && cur.op == OP_FREQ) begin
      div_q <= (cur.divn > `CFA_DIV_MAX) ? `CFA_DIV_MAX : cur.divn;
    end
  end

  // cpu enable pulse once every 2**div cycles
  always_ff @(posedge clock) begin
    if (reset) begin
      div_cnt_q    <= 5'h00;
      cpu_clk_en_q <= 1'b0;
    end else begin
      div_cnt_q    <= div_cnt_q + 5'h01;
      cpu_clk_en_q <= ((div_cnt_q & ((5'h01 << div_q) - 5'h01)) == 5'h00);
    end
  end

  // register port: status readable, control write-only, others read zero
  always_ff @(posedge clock) begin
    if (reset) begin
      bus_rdata_q <= 8'h00;
    end else if (bus_read && bus_addr == `CFA_OFS_STATUS) begin
      bus_rdata_q <= {1'b0, div_q, halted_q, z_q, v_q, c_q};
    end else begin
      bus_rdata_q <= 8'h00;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  sequence s_issue_post;
    issue && instr.mode == AM_POST_INC;
  endsequence
  sequence s_issue;
    issue;
  endsequence

  AST_SUBC: assert property (exec && cur.op == OP_SUBC |=>
    result_q.acc == 8'($past(ox) - $past(oy) - {7'h00, ~$past(c_q)}))
    else $error("subtract with borrow wrong");
  AST_MUL: assert property (exec && cur.op == OP_MUL |=>
    {result_q.reg_v, result_q.acc} == {8'h00, $past(ox)} * {8'h00, $past(oy)})
    else $error("product wrong");
  AST_MSHL: assert property (exec && cur.op == OP_MSHL |=>
    {result_q.reg_v, result_q.acc} == ({8'h00, $past(oy)} << $past(cur.sel)))
    else $error("shift left wrong");
  AST_CMP: assert property (exec && cur.op == OP_CMP |=>
    !result_q.reg_we && (v_q == (c_q && !z_q)))
    else $error("compare flags wrong");
  AST_TSTB: assert property (exec && cur.op == OP_TSTB |=>
    result_q.acc == ($past(oy) & (8'h01 << $past(cur.sel))) && !result_q.reg_we)
    else $error("bit test wrong");
  AST_SETB: assert property (exec && cur.op == OP_SETB |=>
    result_q.acc == ($past(oy) | (8'h01 << $past(cur.sel))) && result_q.acc == result_q.reg_v)
    else $error("bit set wrong");
  AST_SFLAG: assert property (exec && cur.op == OP_SFLAG |=>
    result_q.acc[7] == c_q && result_q.acc[6] == (c_q ^ v_q) && $stable(c_q) && $stable(z_q))
    else $error("flag save wrong");
  AST_RFLAG: assert property (exec && cur.op == OP_RFLAG |=>
    {c_q, result_q.acc} == {$past(oy), 1'b0})
    else $error("flag restore wrong");
  AST_ZERO: assert property (exec && cur.op inside {OP_SUBC, OP_CMP, OP_TSTB, OP_RFLAG} |=>
    z_q == (result_q.acc == 8'h00))
    else $error("zero flag wrong");
  AST_POSTINC: assert property (s_issue_post |=>
    ptr_q[$past(instr.ptr_sel)] == $past(base) + PTR_W'(1) && data_store_addr_q == $past(base))
    else $error("post increment wrong");
  AST_MEMSEQ: assert property (s_issue |=> data_store_rd_q && busy_q ##1 result_valid_q)
    else $error("memory instruction did not complete");
  AST_HALT: assert property (exec && cur.op == OP_HALT && !wake_sync_q[1] && !wake_wr |=>
    halted_q ##1 (halted_q || ($past(wake_sync_q) > 2'h1) || $past(wake_wr)))
    else $error("halt not held");
endmodule : cfa_execute
`default_nettype wire

// ===== pkg/cfa_defines.svh
// register offsets, field positions, reset values and timing constants of the execute block
`ifndef CFA_DEFINES_SVH
`define CFA_DEFINES_SVH
`define CFA_OFS_STATUS   2'h0
`define CFA_OFS_CTRL     2'h1
`define CFA_ST_C         0
`define CFA_ST_V         1
`define CFA_ST_Z         2
`define CFA_ST_HALT      3
`define CFA_ST_DIV_LO    4
`define CFA_ST_DIV_HI    6
`define CFA_CTRL_WAKE    0
`define CFA_RST_DIV      3'h0
`define CFA_RST_PTR      16'h0000
`define CFA_DIV_MAX      3'h4
`define CFA_DIRECT_PAGE  8'h00
`endif

// ===== pkg/cfa_pkg.sv
// types shared by the execute block and its decoder
package cfa_pkg;
  typedef enum logic [3:0] {
    OP_NOP, OP_SUBC, OP_MUL, OP_MSHL, OP_MSHR, OP_MSHRA, OP_CMP, OP_TSTB,
    OP_SETB, OP_CLRB, OP_INVB, OP_SFLAG, OP_RFLAG, OP_FREQ, OP_HALT, OP_JUMP
  } cfa_op_e;
  typedef enum logic [2:0] {
    AM_DIRECT, AM_IDX, AM_IDX_IMM, AM_IDX_R3, AM_POST_INC, AM_POST_OFS, AM_PRE_DEC, AM_PRE_OFS
  } cfa_mode_e;
  typedef enum logic [3:0] {
    CC_CS, CC_CC, CC_ZS, CC_ZC, CC_VS, CC_VC, CC_EV,
    CC_EQ, CC_NE, CC_GT, CC_GE, CC_LT, CC_LE
  } cfa_cc_e;
  typedef struct packed {
    cfa_op_e   op;
    logic [7:0] x;
    logic [7:0] y;
    logic [7:0] imm;
    logic [2:0] sel;
    cfa_mode_e mode;
    logic [1:0] ptr_sel;
    logic [1:0] mem_slot;
    cfa_cc_e   cc;
    logic [2:0] divn;
  } cfa_instr_s;
  typedef struct packed {
    logic       acc_we;
    logic [7:0] acc;
    logic       reg_we;
    logic [7:0] reg_v;
  } cfa_result_s;
endpackage : cfa_pkg
